// >>> rtl/spi_nand_serial_front_end.sv
// Serial host front end: lane shifting on the host clock, byte streams on clk_i.
// Assumes frame settings stay stable for a whole frame and the core drains bytes promptly.
`timescale 1ns/100ps
module spi_nand_serial_front_end #(
	parameter int TX_DEPTH = spi_front_pkg::TX_FIFO_DEPTH
) (
	// User clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Serial link pins
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic io_lane0_i,
	input wire logic io_lane1_i,
	input wire logic io_lane2_i,
	input wire logic io_lane3_i,
	output logic io_lane0_o,
	output logic io_lane1_o,
	output logic io_lane2_o,
	output logic io_lane3_o,
	output logic io_lane0_oe_o,
	output logic io_lane1_oe_o,
	output logic io_lane2_oe_o,
	output logic io_lane3_oe_o,
	// Frame settings
	input wire logic [spi_front_pkg::CNT_W-1:0] hdr_bytes_i,
	input wire spi_front_pkg::lanes_e data_lanes_i,
	input wire logic data_read_i,
	input wire logic [1:0] addr_bytes_i,
	// Received bytes
	output logic [spi_front_pkg::BYTE_W-1:0] rx_data_o,
	output logic rx_first_o,
	output logic rx_valid_o,
	input wire logic rx_ready_i,
	output logic rx_overrun_o,
	// Bytes to send
	input wire logic [spi_front_pkg::BYTE_W-1:0] tx_data_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	output logic tx_underrun_o,
	// Frame state
	output logic frame_active_o,
	output logic frame_end_o,
	// Address decode
	output logic addr_valid_o,
	output logic [spi_front_pkg::COL_W-1:0] column_addr_o,
	output logic column_spare_o,
	output logic column_oob_o,
	output logic [spi_front_pkg::ROW_W-1:0] row_addr_o,
	output logic [spi_front_pkg::PAGE_W-1:0] page_sel_o,
	output logic [spi_front_pkg::BLOCK_W-1:0] block_sel_o
);
	import spi_front_pkg::*;

	if ((1 << PAGE_W) != PAGES_PER_BLOCK || (1 << BLOCK_W) != BLOCK_COUNT) begin : g_bad_geom
		$error("row address fields do not match the array geometry");
	end
	if (PAGE_BYTES > (1 << COL_W) || TX_DEPTH < 2) begin : g_bad_cfg
		$error("column width or FIFO depth cannot serve this front end");
	end

	// Link domain state, rising edge
	logic [CNT_W-1:0] hdr_s1;
	logic [CNT_W-1:0] hdr_s2;
	lanes_e lanes_s1;
	lanes_e lanes_s2;
	logic read_s1;
	logic read_s2;
	logic [2:0] bit_cnt;
	logic [CNT_W-1:0] byte_cnt;
	logic [BYTE_W-1:0] rx_sh;
	logic [RX_W-1:0] rx_word;
	logic rx_tgl;
	logic held;
	logic [2:0] next_bit_cnt;
	logic [CNT_W-1:0] next_byte_cnt;
	logic [BYTE_W-1:0] next_rx_sh;
	logic [RX_W-1:0] next_rx_word;
	logic next_rx_tgl;
	logic next_held;
	logic hdr_phase;
	logic read_phase;
	lanes_e cur_lanes;
	logic paused;
	logic [3:0] pins_in;
	logic [3:0] bit_sum;

	// Link domain state, falling edge
	logic full_s1;
	logic full_s2;
	logic [BYTE_W-1:0] tx_sh;
	logic [3:0] pins_q;
	logic [3:0] oe_q;
	logic take_tgl;
	logic und;
	logic [BYTE_W-1:0] next_tx_sh;
	logic [3:0] next_pins_q;
	logic [3:0] next_oe_q;
	logic next_take_tgl;
	logic next_und;
	logic [BYTE_W-1:0] load;

	// User domain state
	logic cs_s1;
	logic cs_s2;
	logic cs_prev;
	logic rx_s1;
	logic rx_s2;
	logic rx_s3;
	logic take_s1;
	logic take_s2;
	logic take_prev;
	logic take_d;
	logic und_s1;
	logic und_s2;
	logic rx_evt;
	logic [RX_W-1:0] rx_cap;
	logic [BYTE_W-1:0] tx_word;
	logic tx_have;
	logic full_tgl;
	logic [IDX_W-1:0] idx;
	logic [ADDR_SH_W-1:0] addr_sh;
	logic next_frame_active;
	logic next_frame_end;
	logic next_rx_evt;
	logic [RX_W-1:0] next_rx_cap;
	logic [BYTE_W-1:0] next_rx_data;
	logic next_rx_first;
	logic next_rx_valid;
	logic next_rx_overrun;
	logic next_take_prev;
	logic next_take_d;
	logic [BYTE_W-1:0] next_tx_word;
	logic next_tx_have;
	logic next_full_tgl;
	logic [IDX_W-1:0] next_idx;
	logic [ADDR_SH_W-1:0] next_addr_sh;
	logic next_addr_valid;
	logic [COL_W-1:0] next_column;
	logic next_spare;
	logic next_oob;
	logic [ROW_W-1:0] next_row;
	logic deliver;
	logic [IDX_W-1:0] idx_step;

	byte_stream_if #(.WIDTH(BYTE_W)) tx_in ();
	byte_stream_if #(.WIDTH(BYTE_W)) tx_out ();

	assign tx_in.data = tx_data_i;
	assign tx_in.valid = tx_valid_i;
	assign tx_ready_o = tx_in.ready;
	assign tx_out.ready = !tx_have;

	stream_fifo #(.WIDTH(BYTE_W), .DEPTH(TX_DEPTH)) u_tx_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.fill(tx_in),
		.drain(tx_out)
	);

	// Frame settings into the serial clock domain
	always_ff @(posedge sclk_i) begin
		hdr_s1 <= hdr_bytes_i;
		hdr_s2 <= hdr_s1;
		lanes_s1 <= data_lanes_i;
		lanes_s2 <= lanes_s1;
		read_s1 <= data_read_i;
		read_s2 <= read_s1;
	end

	// Header on one lane, then the data phase on the chosen lanes
	always_comb begin
		hdr_phase = (byte_cnt < hdr_s2);
		cur_lanes = hdr_phase ? LANES_1 : lanes_s2; // see (RULE9) see (RULE10)
		read_phase = read_s2 && !hdr_phase;
		pins_in = {io_lane3_i, io_lane2_i, io_lane1_i, io_lane0_i};
		paused = !io_lane3_i && (cur_lanes != LANES_4); // see (RULE16)
		bit_sum = {1'b0, bit_cnt} + lane_step(cur_lanes);
		next_bit_cnt = bit_cnt;
		next_byte_cnt = byte_cnt;
		next_rx_sh = rx_sh;
		next_rx_word = rx_word;
		next_rx_tgl = rx_tgl;
		next_held = paused;
		if (!paused) begin
			next_bit_cnt = bit_sum[2:0];
			if (!read_phase) begin
				next_rx_sh = shift_in(rx_sh, pins_in, cur_lanes); // see (RULE1) see (RULE11) see (RULE17)
			end
			if (bit_sum[3]) begin
				if (byte_cnt != '1) begin
					next_byte_cnt = byte_cnt + 1'b1;
				end
				if (!read_phase) begin
					next_rx_word = {byte_cnt == '0, next_rx_sh};
					next_rx_tgl = !rx_tgl;
				end
			end
		end
	end

	// Capture on the rising edge works alike for mode zero and three
	always_ff @(posedge sclk_i or posedge cs_n_i) begin // see (RULE3) see (RULE4) see (RULE15)
		if (cs_n_i) begin // see (RULE8) see (RULE17)
			bit_cnt <= '0;
			byte_cnt <= '0;
			rx_sh <= '0;
			rx_word <= '0;
			rx_tgl <= 1'b0;
			held <= 1'b0;
		end else begin
			bit_cnt <= next_bit_cnt;
			byte_cnt <= next_byte_cnt;
			rx_sh <= next_rx_sh;
			rx_word <= next_rx_word;
			rx_tgl <= next_rx_tgl;
			held <= next_held;
		end
	end

	// Offer toggle into the falling edge domain
	always_ff @(negedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			full_s1 <= 1'b0;
			full_s2 <= 1'b0;
		end else begin
			full_s1 <= full_tgl;
			full_s2 <= full_s1;
		end
	end

	// Launch of read data after each falling edge
	always_comb begin
		load = tx_sh;
		next_tx_sh = tx_sh;
		next_pins_q = pins_q;
		next_oe_q = '0;
		next_take_tgl = take_tgl;
		next_und = und;
		if (read_phase && !held) begin
			next_oe_q = lane_oe(cur_lanes); // see (RULE9) see (RULE10)
			if (bit_cnt == '0) begin
				load = (full_s2 != take_tgl) ? tx_word : FILL_BYTE;
				next_take_tgl = take_tgl ^ (full_s2 != take_tgl);
				next_und = und | (full_s2 == take_tgl);
			end
			next_pins_q = lane_bits(load, cur_lanes); // see (RULE2) see (RULE11) see (RULE17)
			next_tx_sh = shift_out(load, cur_lanes);
		end
	end

	always_ff @(negedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin // see (RULE5)
			tx_sh <= '0;
			pins_q <= '0;
			oe_q <= '0;
			take_tgl <= 1'b0;
			und <= 1'b0;
		end else begin
			tx_sh <= next_tx_sh;
			pins_q <= next_pins_q;
			oe_q <= next_oe_q;
			take_tgl <= next_take_tgl;
			und <= next_und;
		end
	end

	assign io_lane0_o = pins_q[0];
	assign io_lane1_o = pins_q[1];
	assign io_lane2_o = pins_q[2];
	assign io_lane3_o = pins_q[3];
	assign io_lane0_oe_o = oe_q[0];
	assign io_lane1_oe_o = oe_q[1];
	assign io_lane2_oe_o = oe_q[2];
	assign io_lane3_oe_o = oe_q[3];

	// Link levels into the user domain
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cs_s1 <= 1'b0;
			cs_s2 <= 1'b0;
			rx_s1 <= 1'b0;
			rx_s2 <= 1'b0;
			rx_s3 <= 1'b0;
			take_s1 <= 1'b0;
			take_s2 <= 1'b0;
			und_s1 <= 1'b0;
			und_s2 <= 1'b0;
		end else begin
			cs_s1 <= cs_n_i;
			cs_s2 <= cs_s1;
			rx_s1 <= rx_tgl;
			rx_s2 <= rx_s1;
			rx_s3 <= rx_s2;
			take_s1 <= take_tgl;
			take_s2 <= take_s1;
			und_s1 <= und;
			und_s2 <= und_s1;
		end
	end

	// Frames, received bytes, transmit offers and address decode
	always_comb begin
		next_frame_end = frame_active_o && cs_s2;
		next_frame_active = frame_active_o;
		if (cs_s2) begin
			next_frame_active = 1'b0;
		end else if (cs_prev) begin
			next_frame_active = 1'b1; // see (RULE7) see (RULE8)
		end
		next_rx_evt = !cs_s2 && (rx_s2 != rx_s3);
		next_rx_cap = next_rx_evt ? rx_word : rx_cap;
		deliver = rx_evt && frame_active_o && !cs_s2; // see (RULE17)
		next_rx_data = rx_data_o;
		next_rx_first = rx_first_o;
		next_rx_valid = rx_valid_o && !rx_ready_i;
		next_rx_overrun = rx_overrun_o;
		if (cs_prev && !cs_s2) begin
			next_rx_overrun = 1'b0;
		end
		if (deliver) begin
			next_rx_overrun = next_rx_overrun | next_rx_valid;
			next_rx_data = rx_cap[BYTE_W-1:0];
			next_rx_first = rx_cap[BYTE_W];
			next_rx_valid = 1'b1;
		end
		next_take_prev = cs_s2 ? 1'b0 : take_s2;
		next_take_d = !cs_s2 && (take_s2 != take_prev);
		next_tx_word = tx_word;
		next_tx_have = tx_have;
		next_full_tgl = full_tgl;
		if (cs_s2) begin
			next_full_tgl = 1'b0;
		end else if (take_d) begin
			next_tx_have = 1'b0;
		end else if (tx_have && full_tgl == take_prev) begin
			next_full_tgl = !full_tgl;
		end
		if (!tx_have && tx_out.valid) begin
			next_tx_word = tx_out.data;
			next_tx_have = 1'b1;
		end
		idx_step = (idx != '1) ? idx + 1'b1 : idx;
		next_idx = idx;
		next_addr_sh = addr_sh;
		next_addr_valid = 1'b0;
		if (deliver) begin
			next_idx = rx_cap[BYTE_W] ? '0 : idx_step;
			if (!rx_cap[BYTE_W] && idx_step <= IDX_W'(addr_bytes_i)) begin
				next_addr_sh = {addr_sh[ADDR_SH_W-BYTE_W-1:0], rx_cap[BYTE_W-1:0]}; // see (RULE17)
				next_addr_valid = (idx_step == IDX_W'(addr_bytes_i));
			end
		end
		next_column = next_addr_sh[COL_W-1:0];
		next_row = next_addr_sh[ROW_W-1:0];
		next_oob = (next_column > LAST_COLUMN); // see (RULE12)
		next_spare = !next_oob && (next_column >= FIRST_SPARE); // see (RULE14)
	end

	// Deselect of an active frame raises frame_end_o and drops frame_active_o; operations behind the core run on
	always_ff @(posedge clk_i) begin // see (RULE6)
		if (rst_i) begin
			cs_prev <= 1'b0;
			frame_active_o <= 1'b0;
			frame_end_o <= 1'b0;
			rx_evt <= 1'b0;
			rx_cap <= '0;
			rx_data_o <= '0;
			rx_first_o <= 1'b0;
			rx_valid_o <= 1'b0;
			rx_overrun_o <= 1'b0;
			take_prev <= 1'b0;
			take_d <= 1'b0;
			tx_word <= '0;
			tx_have <= 1'b0;
			full_tgl <= 1'b0;
			tx_underrun_o <= 1'b0;
			idx <= '0;
			addr_sh <= '0;
			addr_valid_o <= 1'b0;
			column_addr_o <= '0;
			column_spare_o <= 1'b0;
			column_oob_o <= 1'b0;
			row_addr_o <= '0;
			page_sel_o <= '0;
			block_sel_o <= '0;
		end else begin
			cs_prev <= cs_s2;
			frame_active_o <= next_frame_active;
			frame_end_o <= next_frame_end;
			rx_evt <= next_rx_evt;
			rx_cap <= next_rx_cap;
			rx_data_o <= next_rx_data;
			rx_first_o <= next_rx_first;
			rx_valid_o <= next_rx_valid;
			rx_overrun_o <= next_rx_overrun;
			take_prev <= next_take_prev;
			take_d <= next_take_d;
			tx_word <= next_tx_word;
			tx_have <= next_tx_have;
			full_tgl <= next_full_tgl;
			tx_underrun_o <= und_s2;
			idx <= next_idx;
			addr_sh <= next_addr_sh;
			addr_valid_o <= next_addr_valid;
			if (next_addr_valid) begin
				column_addr_o <= next_column;
				column_spare_o <= next_spare;
				column_oob_o <= next_oob;
				row_addr_o <= next_row;
				page_sel_o <= page_of(next_row); // see (RULE13)
				block_sel_o <= block_of(next_row); // see (RULE13) see (RULE14)
			end
		end
	end
endmodule : spi_nand_serial_front_end

// >>> rtl/spi_front_pkg.sv
// Constants, lane codes and address helpers of the serial NAND front end.
// Assumes link logic on the host serial clock and user logic on clk_i.
//
// Behaviour
// (RULE1) Single-lane instruction, address and write bits are captured on the rising serial clock.
// (RULE2) Outgoing bits change only after a falling serial clock so the host samples on the rise.
// (RULE3) Clock modes zero-zero and one-one both work with no setting at all.
// (RULE4) The host keeps the clock low at both select edges in mode zero and high in mode three.
// (RULE5) While select is high the device is deselected and every data lane is released.
// (RULE6) Deselecting never stops a page read, erase, program or reset already running inside.
// (RULE7) After power-up nothing is accepted until select has gone from high to low.
// (RULE8) Select low enables instruction input and data output on the serial lanes.
// (RULE9) Two-lane transfers use lanes zero and one as bidirectional pins, two bits per clock.
// (RULE10) Four-lane transfers add lanes two and three, four bits per clock.
// (RULE11) In multi-lane transfers data is latched on rising edges and shifted out on falling edges.
// (RULE12) The column address is 12 bits but only positions up to 2175 exist.
// (RULE13) Row address bits five to zero pick the page and bits fifteen to six pick the block.
// (RULE14) The array is 1024 blocks of 64 pages, each page 2048 main plus 128 spare bytes.
// (RULE15) Serial clock rates up to 104 MHz are supported and the host stays at or below that.
// (RULE16) The pause function is off whenever a four-lane transfer is active.
// (RULE17) Bytes go most significant bit first and a partial command is dropped when select rises.
package spi_front_pkg;
	localparam int BYTE_W = 8;
	localparam int RX_W = BYTE_W + 1;
	localparam int CNT_W = 8;
	localparam int IDX_W = 3;
	localparam int ADDR_SH_W = 24;
	localparam int COL_W = 12;
	localparam int ROW_W = 16;
	localparam int PAGE_LSB = 0;
	localparam int PAGE_W = 6;
	localparam int BLOCK_LSB = 6;
	localparam int BLOCK_W = 10;
	localparam int PAGES_PER_BLOCK = 64;
	localparam int BLOCK_COUNT = 1024;
	localparam int MAIN_BYTES = 2048;
	localparam int SPARE_BYTES = 128;
	localparam int PAGE_BYTES = MAIN_BYTES + SPARE_BYTES;
	localparam logic [COL_W-1:0] LAST_COLUMN = COL_W'(PAGE_BYTES - 1);
	localparam logic [COL_W-1:0] FIRST_SPARE = COL_W'(MAIN_BYTES);
	localparam int SCLK_MAX_MHZ = 104;
	localparam int CLK_MHZ = 100;
	localparam int TX_FIFO_DEPTH = 4;
	localparam logic [BYTE_W-1:0] FILL_BYTE = 8'hFF;
	localparam logic [3:0] STEP_1 = 4'h1;
	localparam logic [3:0] STEP_2 = 4'h2;
	localparam logic [3:0] STEP_4 = 4'h4;
	localparam logic [3:0] OE_1 = 4'h2;
	localparam logic [3:0] OE_2 = 4'h3;
	localparam logic [3:0] OE_4 = 4'hF;

	typedef enum logic [1:0] {LANES_1, LANES_2, LANES_4} lanes_e;

	function automatic logic [3:0] lane_step(input lanes_e l);
		unique case (l)
			LANES_2: lane_step = STEP_2;
			LANES_4: lane_step = STEP_4;
			default: lane_step = STEP_1;
		endcase
	endfunction : lane_step

	function automatic logic [3:0] lane_oe(input lanes_e l);
		unique case (l)
			LANES_2: lane_oe = OE_2;
			LANES_4: lane_oe = OE_4;
			default: lane_oe = OE_1;
		endcase
	endfunction : lane_oe

	// Top bits of a byte onto the lanes, highest driven lane first (lane 1 alone on one lane)
	function automatic logic [3:0] lane_bits(input logic [BYTE_W-1:0] b, input lanes_e l);
		unique case (l)
			LANES_2: lane_bits = {2'h0, b[7:6]};
			LANES_4: lane_bits = b[7:4];
			default: lane_bits = {2'h0, b[7], 1'h0};
		endcase
	endfunction : lane_bits

	function automatic logic [BYTE_W-1:0] shift_in(input logic [BYTE_W-1:0] sh,
			input logic [3:0] pins, input lanes_e l);
		unique case (l)
			LANES_2: shift_in = {sh[5:0], pins[1:0]};
			LANES_4: shift_in = {sh[3:0], pins[3:0]};
			default: shift_in = {sh[6:0], pins[0]};
		endcase
	endfunction : shift_in

	function automatic logic [BYTE_W-1:0] shift_out(input logic [BYTE_W-1:0] sh, input lanes_e l);
		shift_out = sh << lane_step(l);
	endfunction : shift_out

	function automatic logic [PAGE_W-1:0] page_of(input logic [ROW_W-1:0] row);
		page_of = row[PAGE_LSB +: PAGE_W];
	endfunction : page_of

	function automatic logic [BLOCK_W-1:0] block_of(input logic [ROW_W-1:0] row);
		block_of = row[BLOCK_LSB +: BLOCK_W];
	endfunction : block_of
endpackage : spi_front_pkg

// >>> rtl/byte_stream_if.sv
// Valid and ready stream carrier between the front end and its FIFO.
// Assumes both ends share one clock.
`timescale 1ns/100ps
interface byte_stream_if #(parameter int WIDTH = 8);
	logic [WIDTH-1:0] data;
	logic valid;
	logic ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface : byte_stream_if

// >>> rtl/stream_fifo.sv
// Single-clock FIFO with valid and ready on both sides.
// Assumes synchronous active-high reset; ready on the fill side is a register.
`timescale 1ns/100ps
module stream_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Streams
	byte_stream_if.snk fill,
	byte_stream_if.src drain
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	if (DEPTH < 2) begin : g_bad_depth
		$error("stream_fifo needs at least two words");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic full;
	logic [AW-1:0] next_wr_ptr;
	logic [AW-1:0] next_rd_ptr;
	logic [AW:0] next_count;
	logic next_full;
	logic push;
	logic pop;

	assign fill.ready = !full;
	assign drain.valid = (count != '0);
	assign drain.data = mem[rd_ptr];

	always_comb begin
		push = fill.valid && !full;
		pop = drain.valid && drain.ready;
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		if (push) begin
			next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
		end
		if (pop) begin
			next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
		end
		next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		next_full = (next_count == (AW + 1)'(DEPTH));
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			full <= 1'b0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
			full <= next_full;
		end
	end

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr] <= fill.data;
		end
	end
endmodule : stream_fifo

// >>> test/spi_front_end_chk.sv
// Concurrent checks on the serial front end ports, bound into the top module.
// Assumes all checks are sampled on clk_i, which runs much faster than the link clock.
`timescale 1ns/100ps
module spi_front_end_chk (
	// Clocks and select
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	// Lanes and settings
	input wire logic io_lane0_o,
	input wire logic io_lane1_o,
	input wire logic io_lane2_o,
	input wire logic io_lane3_o,
	input wire logic io_lane0_oe_o,
	input wire logic io_lane1_oe_o,
	input wire logic io_lane2_oe_o,
	input wire logic io_lane3_oe_o,
	input wire spi_front_pkg::lanes_e data_lanes_i,
	input wire logic data_read_i,
	// User side
	input wire logic [spi_front_pkg::BYTE_W-1:0] rx_data_o,
	input wire logic rx_valid_o,
	input wire logic rx_ready_i,
	input wire logic rx_overrun_o,
	input wire logic frame_active_o,
	input wire logic addr_valid_o,
	input wire logic [spi_front_pkg::COL_W-1:0] column_addr_o,
	input wire logic column_spare_o,
	input wire logic column_oob_o,
	input wire logic [spi_front_pkg::ROW_W-1:0] row_addr_o,
	input wire logic [spi_front_pkg::PAGE_W-1:0] page_sel_o,
	input wire logic [spi_front_pkg::BLOCK_W-1:0] block_sel_o
);
	import spi_front_pkg::*;
	logic [3:0] oe;
	logic [3:0] dq;
	logic [3:0] exp_oe;
	assign oe = {io_lane3_oe_o, io_lane2_oe_o, io_lane1_oe_o, io_lane0_oe_o};
	assign dq = {io_lane3_o, io_lane2_o, io_lane1_o, io_lane0_o};
	assign exp_oe = (data_lanes_i == LANES_4) ? 4'hF : ((data_lanes_i == LANES_2) ? 4'h3 : 4'h2);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_deselect;
		frame_active_o ##1 $rose(cs_n_i);
	endsequence
	sequence s_closed;
		##[1:10] !frame_active_o;
	endsequence
	a_desel_release: assert property (cs_n_i |-> oe == 4'h0)
		else $error("lane driven while deselected");
	a_rise_stable: assert property ((sclk_i && $past(sclk_i) && !cs_n_i && !$past(cs_n_i))
		|-> $stable({dq, oe}))
		else $error("lane output changed while serial clock high");
	a_read_lanes: assert property ((!cs_n_i && oe != 4'h0) |-> oe == exp_oe)
		else $error("wrong set of lanes driven");
	a_write_quiet: assert property (!data_read_i |-> oe == 4'h0)
		else $error("lane driven in a receive frame");
	a_addr_split: assert property (addr_valid_o |-> (page_sel_o == row_addr_o[5:0])
		&& (block_sel_o == row_addr_o[15:6]))
		else $error("page or block select wrong");
	a_column_class: assert property (addr_valid_o |-> (column_oob_o == (column_addr_o > 12'h87F))
		&& (column_spare_o == (column_addr_o >= 12'h800 && column_addr_o <= 12'h87F)))
		else $error("column range flags wrong");
	a_rx_hold: assert property ((rx_valid_o && !rx_ready_i) |=> rx_valid_o
		&& ($stable(rx_data_o) || rx_overrun_o))
		else $error("received byte lost before accept");
	a_frame_close: assert property (s_deselect |-> s_closed)
		else $error("frame still active after select rose");
	a_idle_inactive: assert property (cs_n_i [*8] |-> !frame_active_o)
		else $error("frame active while deselected");
endmodule : spi_front_end_chk

bind spi_nand_serial_front_end spi_front_end_chk u_chk (.clk_i, .rst_i, .sclk_i, .cs_n_i,
	.io_lane0_o, .io_lane1_o, .io_lane2_o, .io_lane3_o, .io_lane0_oe_o, .io_lane1_oe_o,
	.io_lane2_oe_o, .io_lane3_oe_o, .data_lanes_i, .data_read_i, .rx_data_o, .rx_valid_o,
	.rx_ready_i, .rx_overrun_o, .frame_active_o, .addr_valid_o, .column_addr_o,
	.column_spare_o, .column_oob_o, .row_addr_o, .page_sel_o, .block_sel_o);

// >>> test/spi_host_model.sv
// Behavioural serial bus host driving clock, select and lanes of the front end.
// Assumes the bench fills tx_q before a frame and reads rx_q after it.
`timescale 1ns/100ps
module spi_host_model (
	// From the device
	input wire logic [3:0] dout_i,
	input wire logic [3:0] doe_i,
	// To the device
	output logic sclk_o,
	output logic cs_n_o,
	output logic [3:0] lane_o
);
	import spi_front_pkg::*;
	localparam realtime HALF = 62.5;
	logic [3:0] drv = 4'hF;
	logic [3:0] hen = 4'hF;
	logic [3:0] junk = 4'h5;
	logic [7:0] tx_q[$];
	logic [7:0] rx_q[$];
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		#1 cs_n_o = 1'b0;
	end
	// Released lanes toggle on every clock edge
	always @(sclk_o) junk <= ~junk;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			lane_o[i] = (doe_i[i] === 1'b1) ? dout_i[i] : (hen[i] ? drv[i] : junk[i]);
		end
	end
	// Clocking with select low from power-up, never accepted
	task automatic stray();
		repeat (16) begin
			drv = {3'h7, ~drv[0]};
			#(HALF) sclk_o = 1'b1;
			#(HALF) sclk_o = 1'b0;
		end
		cs_n_o = 1'b1;
	endtask : stray
	task automatic frame(input bit m3, input int hdr, input lanes_e ln, input bit rd);
		int st;
		logic [7:0] b;
		logic [7:0] r;
		sclk_o = m3;
		#(HALF) cs_n_o = 1'b0;
		foreach (tx_q[k]) begin
			st = (k < hdr || ln == LANES_1) ? 1 : ((ln == LANES_2) ? 2 : 4);
			b = tx_q[k];
			for (int n = 0; n < 8; n += st) begin
				sclk_o = 1'b0;
				hen = (k >= hdr && rd) ? ((st == 4) ? 4'h0 : 4'hC) : 4'hF;
				drv = (st == 4) ? b[7-n -: 4] : ((st == 2) ? {2'h3, b[7-n -: 2]} : {3'h7, b[7-n]});
				#(HALF) sclk_o = 1'b1;
				r = (st == 4) ? {r[3:0], lane_o} : ((st == 2) ? {r[5:0], lane_o[1:0]} : {r[6:0], lane_o[1]});
				#(HALF);
			end
			if (k >= hdr && rd) rx_q.push_back(r);
		end
		sclk_o = m3;
		hen = 4'hF;
		#(HALF) cs_n_o = 1'b1;
		#(4 * HALF);
	endtask : frame
endmodule : spi_host_model

// >>> test/tb_spi_nand_serial_front_end.sv
// Self-checking bench of the serial front end.
// Assumes the host model drives the link and the bench drives the user side.
`timescale 1ns/100ps
`define CHECK(nm, ex, got) begin \
	n_tests++; \
	if ((got) !== (ex)) begin \
		errors++; \
		$display("wrong value %s expected %0h seen %0h", nm, ex, got); \
	end \
end
module tb_spi_nand_serial_front_end;
	import spi_front_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic sclk_i, cs_n_i, io_lane0_i, io_lane1_i, io_lane2_i, io_lane3_i;
	logic io_lane0_o, io_lane1_o, io_lane2_o, io_lane3_o;
	logic io_lane0_oe_o, io_lane1_oe_o, io_lane2_oe_o, io_lane3_oe_o;
	logic [3:0] lane_in;
	logic [7:0] hdr_bytes_i = 8'h01;
	lanes_e data_lanes_i = LANES_1;
	logic data_read_i = 1'b0;
	logic [1:0] addr_bytes_i = 2'h0;
	logic [7:0] rx_data_o;
	logic [7:0] tx_data_i = 8'h00;
	logic rx_first_o, rx_valid_o, rx_overrun_o, tx_ready_o, tx_underrun_o;
	logic rx_ready_i = 1'b0;
	logic tx_valid_i = 1'b0;
	logic frame_active_o, frame_end_o, addr_valid_o, column_spare_o, column_oob_o;
	logic [11:0] column_addr_o;
	logic [15:0] row_addr_o;
	logic [5:0] page_sel_o;
	logic [9:0] block_sel_o;
	int errors = 0;
	int n_tests = 0;
	int seed = 8233;
	logic [8:0] rxq[$];
	logic [7:0] exp_tx[$];
	logic [45:0] adr_seen;
	logic [1:0] seen;
	logic [15:0] corner[4] = '{16'h087F, 16'h0880, 16'h0800, 16'h0FFF};
	assign {io_lane3_i, io_lane2_i, io_lane1_i, io_lane0_i} = lane_in;
	always #5 clk_i = ~clk_i;
	spi_host_model u_host (
		.dout_i({io_lane3_o, io_lane2_o, io_lane1_o, io_lane0_o}),
		.doe_i({io_lane3_oe_o, io_lane2_oe_o, io_lane1_oe_o, io_lane0_oe_o}),
		.sclk_o(sclk_i), .cs_n_o(cs_n_i), .lane_o(lane_in)
	);
	spi_nand_serial_front_end #(.TX_DEPTH(4)) u_dut (
		.clk_i, .rst_i, .sclk_i, .cs_n_i, .io_lane0_i, .io_lane1_i, .io_lane2_i, .io_lane3_i,
		.io_lane0_o, .io_lane1_o, .io_lane2_o, .io_lane3_o,
		.io_lane0_oe_o, .io_lane1_oe_o, .io_lane2_oe_o, .io_lane3_oe_o,
		.hdr_bytes_i, .data_lanes_i, .data_read_i, .addr_bytes_i,
		.rx_data_o, .rx_first_o, .rx_valid_o, .rx_ready_i, .rx_overrun_o,
		.tx_data_i, .tx_valid_i, .tx_ready_o, .tx_underrun_o, .frame_active_o, .frame_end_o,
		.addr_valid_o, .column_addr_o, .column_spare_o, .column_oob_o,
		.row_addr_o, .page_sel_o, .block_sel_o
	);
	// Consumer stalls at random
	always @(negedge clk_i) rx_ready_i <= 1'($random(seed));
	always @(posedge clk_i) begin
		if (rx_valid_o === 1'b1 && rx_ready_i) rxq.push_back({rx_first_o, rx_data_o});
		seen |= {frame_end_o, tx_underrun_o};
		if (addr_valid_o === 1'b1) begin
			adr_seen = {column_addr_o, row_addr_o, page_sel_o, block_sel_o, column_spare_o,
				column_oob_o};
		end
	end
	function automatic logic [45:0] exp_addr(input logic [15:0] a);
		logic [11:0] c;
		c = a[11:0];
		return {c, a, a[5:0], a[15:6], (c >= 12'h800 && c <= 12'h87F), (c > 12'h87F)};
	endfunction : exp_addr
	task automatic push(input int n, output int taken);
		taken = 0;
		repeat (n) begin
			@(negedge clk_i);
			tx_data_i = 8'($random(seed));
			tx_valid_i = 1'b1;
			@(posedge clk_i);
			if (tx_ready_o === 1'b1) begin
				exp_tx.push_back(tx_data_i);
				taken++;
			end
		end
		@(negedge clk_i);
		tx_valid_i = 1'b0;
	endtask : push
	task automatic run_frame(input bit m3, input lanes_e ln, input bit r, input int na,
			input int nd, input logic [15:0] adr);
		logic [23:0] h;
		logic [7:0] b;
		logic [8:0] e[$];
		logic [7:0] x[$];
		h = {8'($random(seed)), adr};
		@(negedge clk_i);
		hdr_bytes_i = 8'(na + 1);
		data_lanes_i = ln;
		data_read_i = r;
		addr_bytes_i = 2'(na);
		u_host.tx_q = {};
		u_host.rx_q = {};
		rxq = {};
		adr_seen = 'x;
		seen = '0;
		for (int k = 0; k <= na + nd; k++) begin
			b = (k > 0 && k <= na) ? 8'(h >> (8 * (na - k))) : 8'($random(seed));
			u_host.tx_q.push_back(b);
			if (k <= na || !r) e.push_back({k == 0, b});
			else x.push_back((exp_tx.size() > 0) ? exp_tx.pop_front() : 8'hFF);
		end
		u_host.frame(m3, na + 1, ln, r);
		repeat (30) @(negedge clk_i);
		`CHECK("rx count", e.size(), rxq.size())
		foreach (e[k]) `CHECK("rx byte", e[k], rxq[k])
		foreach (x[k]) `CHECK("read byte", x[k], u_host.rx_q[k])
		if (na > 0) `CHECK("address", exp_addr(adr), adr_seen)
		`CHECK("overrun", 1'b0, rx_overrun_o)
		`CHECK("frame end", 1'b1, seen[1])
	endtask : run_frame
	task automatic give_verdict();
		$display("checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	initial begin
		#800000;
		errors++;
		give_verdict();
	end
	initial begin
		int t;
		lanes_e ls[3];
		ls = '{LANES_1, LANES_2, LANES_4};
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		rst_i = 1'b0;
		u_host.stray();
		repeat (20) @(negedge clk_i);
		`CHECK("stray bytes", 0, rxq.size())
		for (int m = 0; m < 2; m++) begin
			foreach (ls[i]) run_frame(m[0], ls[i], 1'b0, 3, 4, 16'($random(seed)));
			foreach (ls[i]) begin
				push(1, t);
				run_frame(m[0], ls[i], 1'b1, 0, 1, 16'h0000);
			end
		end
		foreach (corner[i]) run_frame(1'b0, LANES_1, 1'b0, 2, 0, corner[i]);
		repeat (6) run_frame(1'($random(seed)), ls[$unsigned($random(seed)) % 3], 1'b0, 2, 2,
			16'($random(seed)));
		push(8, t);
		`CHECK("fifo refuses", 1'b1, (t == 4 || t == 5))
		`CHECK("tx ready", 1'b0, tx_ready_o)
		run_frame(1'b0, LANES_1, 1'b1, 0, t + 1, 16'h0000);
		`CHECK("underrun", 1'b1, seen[0])
		`CHECK("tx ready", 1'b1, tx_ready_o)
		give_verdict();
	end
endmodule : tb_spi_nand_serial_front_end
